//--- sysref_clock_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_control_regs (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_spi_sclk,
  input  wire logic i_spi_cs_n,
  input  wire logic i_spi_sdi,
  output logic      o_spi_sdo,
  input  wire logic i_sync_ref,
  output logic      o_sync_event,
  output logic      o_sync_sampled,
  output logic      o_sync_receiver_active,
  output logic      o_device_clock_pecl_mode,
  output logic      o_sync_input_pecl_mode,
  output logic      o_analog_rail_noise_suppress,
  output logic      o_clock_rail_noise_suppress
);
  localparam int AW = sysref_clock_control_pkg::ADDR_W;
  localparam int DW = sysref_clock_control_pkg::DATA_W;
  localparam int PW = sysref_clock_control_pkg::POS_W;
  localparam logic [4:0] CNT_HDR_LAST   = 5'(sysref_clock_control_pkg::HDR_BITS - 1);
  localparam logic [4:0] CNT_FRAME_LAST = 5'(sysref_clock_control_pkg::FRAME_BITS - 1);
  localparam logic [4:0] CNT_DATA_START = 5'(sysref_clock_control_pkg::HDR_BITS);
  localparam int         HDR_MSB_FIX    = sysref_clock_control_pkg::HDR_BITS - 1;

  // pin sampling
  logic          sclk_q;
  logic          sclk_prev_q;
  logic          cs_n_q;
  logic          sdi_q;
  // serial frame state
  logic [4:0]    cnt_q;
  logic [22:0]   shift_q;
  logic          rd_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] out_q;
  logic          sdo_q;
  // registers
  logic [DW-1:0] ctrl_zero_q;
  logic [DW-1:0] ctrl_one_q;
  logic [DW-1:0] ctrl_two_q;
  // driven outputs
  logic          clk_pecl_q;
  logic          sync_pecl_q;
  logic          analog_ns_q;
  logic          clock_ns_q;
  logic          recv_active_q;

  logic          sclk_rise;
  logic          sclk_fall;
  logic [23:0]   shift_next;
  logic          hdr_done;
  logic          frame_done;
  logic          data_phase;
  logic          wr_en;
  logic [AW-1:0] hdr_addr;
  logic [AW-1:0] next_addr;
  logic [AW-1:0] load_addr;
  logic [DW-1:0] load_byte;
  logic          load_en;
  logic [PW-1:0] position;
  logic          wr_zero;
  logic          wr_one;
  logic          wr_two;

  assign sclk_rise  = ~cs_n_q & sclk_q & ~sclk_prev_q;
  assign sclk_fall  = ~cs_n_q & ~sclk_q & sclk_prev_q;
  assign shift_next = {shift_q, sdi_q};
  assign hdr_done   = sclk_rise & (cnt_q == CNT_HDR_LAST);
  assign frame_done = sclk_rise & (cnt_q == CNT_FRAME_LAST);
  assign data_phase = cnt_q >= CNT_DATA_START;
  assign hdr_addr   = shift_next[AW-1:0];
  assign next_addr  = addr_q + AW'(1);
  assign load_en    = hdr_done | frame_done;
  assign load_addr  = hdr_done ? hdr_addr : next_addr;
  assign wr_en      = frame_done & ~rd_q;

  // write decode; status addresses are never write targets
  assign wr_zero = wr_en & (addr_q == sysref_clock_control_pkg::ADDR_CTRL_ZERO);
  assign wr_one  = wr_en & (addr_q == sysref_clock_control_pkg::ADDR_CTRL_ONE);
  assign wr_two  = wr_en & (addr_q == sysref_clock_control_pkg::ADDR_CTRL_TWO);

  // read mux, unmapped reads zero
  assign load_byte =
    (load_addr == sysref_clock_control_pkg::ADDR_CTRL_ZERO) ? ctrl_zero_q :
    (load_addr == sysref_clock_control_pkg::ADDR_CTRL_ONE)  ? ctrl_one_q  :
    (load_addr == sysref_clock_control_pkg::ADDR_CTRL_TWO)  ? ctrl_two_q  :
    (load_addr == sysref_clock_control_pkg::ADDR_POS_LOW)   ? position[7:0]   :
    (load_addr == sysref_clock_control_pkg::ADDR_POS_MID)   ? position[15:8]  :
    (load_addr == sysref_clock_control_pkg::ADDR_POS_HIGH)  ? position[23:16] :
    8'h00;

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sclk_q      <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_n_q      <= 1'b1;
      sdi_q       <= 1'b0;
    end
    else
    begin
      sclk_q      <= i_spi_sclk;
      sclk_prev_q <= sclk_q;
      cs_n_q      <= i_spi_cs_n;
      sdi_q       <= i_spi_sdi;
    end
  end

  // frame counter, header capture, streaming address step
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q   <= 5'h00;
      shift_q <= 23'h000000;
      rd_q    <= 1'b0;
      addr_q  <= '0;
    end
    else if (cs_n_q)
    begin
      cnt_q <= 5'h00;
    end
    else if (sclk_rise)
    begin
      shift_q <= shift_next[22:0];
      if (hdr_done)
      begin
        rd_q   <= shift_next[HDR_MSB_FIX];
        addr_q <= hdr_addr;
        cnt_q  <= CNT_DATA_START;
      end
      else if (frame_done)
      begin
        addr_q <= next_addr;
        cnt_q  <= CNT_DATA_START;
      end
      else
        cnt_q <= cnt_q + 5'h01;
    end
  end

  // read data out, msb first; msb loaded on the rising sclk that ends the header, later bits shift on falling sclk
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      out_q <= 8'h00;
      sdo_q <= 1'b0;
    end
    else if (load_en)
    begin
      out_q <= load_byte;
      sdo_q <= load_byte[DW-1];
    end
    else if (sclk_fall & data_phase)
    begin
      out_q <= {out_q[DW-2:0], 1'b0};
      sdo_q <= out_q[DW-2];
    end
  end

  // register writes store whole byte, reserved bits included
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl_zero_q <= sysref_clock_control_pkg::RST_CTRL_ZERO;
      ctrl_one_q  <= sysref_clock_control_pkg::RST_CTRL_ONE;
      ctrl_two_q  <= sysref_clock_control_pkg::RST_CTRL_TWO;
    end
    else
    begin
      if (wr_zero)
        ctrl_zero_q <= shift_next[DW-1:0];
      if (wr_one)
        ctrl_one_q <= shift_next[DW-1:0];
      if (wr_two)
        ctrl_two_q <= shift_next[DW-1:0];
    end
  end

  // pad controls and rail enables from stored bits
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      clk_pecl_q    <= 1'b0;
      sync_pecl_q   <= 1'b0;
      analog_ns_q   <= 1'b0;
      clock_ns_q    <= 1'b0;
      recv_active_q <= 1'b0;
    end
    else
    begin
      clk_pecl_q    <= ctrl_one_q[sysref_clock_control_pkg::BIT_CLK_PECL];
      sync_pecl_q   <= ctrl_one_q[sysref_clock_control_pkg::BIT_SYNC_PECL];
      analog_ns_q   <= ctrl_two_q[sysref_clock_control_pkg::BIT_ANALOG_NS];
      clock_ns_q    <= ctrl_two_q[sysref_clock_control_pkg::BIT_CLOCK_NS];
      recv_active_q <= ctrl_zero_q[sysref_clock_control_pkg::BIT_RECV_EN];
    end
  end

  sync_window_sampler #(
    .SEL_W (sysref_clock_control_pkg::SEL_W),
    .POS_W (PW)
  ) u_sampler (
    .i_clk              (i_clk),
    .i_reset            (i_reset),
    .i_sync_ref         (i_sync_ref),
    .i_receiver_enable  (ctrl_zero_q[sysref_clock_control_pkg::BIT_RECV_EN]),
    .i_processor_enable (ctrl_zero_q[sysref_clock_control_pkg::BIT_PROC_EN]),
    .i_zoom             (ctrl_zero_q[sysref_clock_control_pkg::BIT_ZOOM]),
    .i_invert           (ctrl_one_q[sysref_clock_control_pkg::BIT_INVERT]),
    .i_delay_select     (ctrl_zero_q[sysref_clock_control_pkg::SEL_MSB:sysref_clock_control_pkg::SEL_LSB]),
    .o_sampled          (o_sync_sampled),
    .o_sync_event       (o_sync_event),
    .o_position         (position)
  );

  assign o_spi_sdo                    = sdo_q;
  assign o_sync_receiver_active       = recv_active_q;
  assign o_device_clock_pecl_mode     = clk_pecl_q;
  assign o_sync_input_pecl_mode       = sync_pecl_q;
  assign o_analog_rail_noise_suppress = analog_ns_q;
  assign o_clock_rail_noise_suppress  = clock_ns_q;
endmodule : sysref_clock_control_regs
`default_nettype wire

//--- sysref_clock_control_pkg.sv
`default_nettype none
package sysref_clock_control_pkg;
  localparam int          ADDR_W           = 15;
  localparam int          DATA_W           = 8;
  localparam int          HDR_BITS         = 16;
  localparam int          FRAME_BITS       = 24;
  localparam logic [14:0] ADDR_CTRL_ZERO   = 15'h0029;
  localparam logic [14:0] ADDR_CTRL_ONE    = 15'h002a;
  localparam logic [14:0] ADDR_CTRL_TWO    = 15'h002b;
  localparam logic [14:0] ADDR_POS_LOW     = 15'h002c;
  localparam logic [14:0] ADDR_POS_MID     = 15'h002d;
  localparam logic [14:0] ADDR_POS_HIGH    = 15'h002e;
  localparam logic [7:0]  RST_CTRL_ZERO    = 8'h80;
  localparam logic [7:0]  RST_CTRL_ONE     = 8'h00;
  localparam logic [7:0]  RST_CTRL_TWO     = 8'h10;
  localparam logic [23:0] RST_POS          = 24'h000000;
  localparam int          BIT_PROC_EN      = 6;
  localparam int          BIT_RECV_EN      = 5;
  localparam int          BIT_ZOOM         = 4;
  localparam int          SEL_MSB          = 3;
  localparam int          SEL_LSB          = 0;
  localparam int          BIT_CLK_PECL     = 2;
  localparam int          BIT_SYNC_PECL    = 1;
  localparam int          BIT_INVERT       = 0;
  localparam int          BIT_ANALOG_NS    = 2;
  localparam int          BIT_CLOCK_NS     = 0;
  localparam int          SEL_W            = 4;
  localparam int          POS_W            = 24;
endpackage : sysref_clock_control_pkg
`default_nettype wire

//--- sync_window_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module sync_window_sampler #(
  parameter int SEL_W = 4,
  parameter int POS_W = 24
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_sync_ref,
  input  wire logic             i_receiver_enable,
  input  wire logic             i_processor_enable,
  input  wire logic             i_zoom,
  input  wire logic             i_invert,
  input  wire logic [SEL_W-1:0] i_delay_select,
  output logic                  o_sampled,
  output logic                  o_sync_event,
  output logic [POS_W-1:0]      o_position
);
  localparam int HIST_W = 2 * POS_W;

  logic [HIST_W-1:0] hist_q;
  logic              sampled_q;
  logic              event_q;
  logic [POS_W-1:0]  pos_q;
  logic              recv_in;
  logic [SEL_W:0]    tap;
  logic              tap_val;
  logic              edge_seen;
  logic [POS_W-1:0]  pos_view;

  // receiver gate and polarity
  assign recv_in   = i_receiver_enable & (i_sync_ref ^ i_invert);
  // zoom halves the delay step
  assign tap       = i_zoom ? {1'b0, i_delay_select} : {i_delay_select, 1'b0};
  assign tap_val   = hist_q[tap];
  assign edge_seen = hist_q[0] & ~hist_q[1];

  genvar k;
  generate
    for (k = 0; k < POS_W; k++)
    begin : g_pos
      assign pos_view[k] = i_zoom ? hist_q[k] : hist_q[2*k];
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      hist_q    <= '0;
      sampled_q <= 1'b0;
      event_q   <= 1'b0;
      pos_q     <= sysref_clock_control_pkg::RST_POS;
    end
    else
    begin
      hist_q    <= {hist_q[HIST_W-2:0], recv_in};
      sampled_q <= tap_val;
      event_q   <= i_processor_enable & tap_val & ~sampled_q;
      if (edge_seen)
        pos_q <= pos_view;
    end
  end

  assign o_sampled    = sampled_q;
  assign o_sync_event = event_q;
  assign o_position   = pos_q;
endmodule : sync_window_sampler
`default_nettype wire

//--- sync_source.sv
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  input  wire logic i_clk,
  input  wire logic i_go,
  output logic      o_sync_ref
);
  int cnt_q;
  // edges launched on the device clock, held high for forty cycles
  always_ff @(posedge i_clk)
  begin
    if (i_go) cnt_q <= 40;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
  end
  assign o_sync_ref = (cnt_q > 0);
endmodule : sync_source
`default_nettype wire

//--- sysref_clock_control_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_control_regs_checker (
  input wire logic i_clk, i_reset, i_spi_sclk, i_spi_cs_n, i_spi_sdi, o_spi_sdo, i_sync_ref,
  input wire logic o_sync_event, o_sync_sampled, o_sync_receiver_active, o_device_clock_pecl_mode,
  input wire logic o_sync_input_pecl_mode, o_analog_rail_noise_suppress, o_clock_rail_noise_suppress
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_RESET_QUIET: assert property (disable iff (1'b0) i_reset |-> !(o_sync_event | o_sync_sampled | o_spi_sdo
    | o_sync_receiver_active | o_device_clock_pecl_mode | o_sync_input_pecl_mode
    | o_analog_rail_noise_suppress | o_clock_rail_noise_suppress)) else $error("outputs set in reset");
  AST_EVENT_PULSE: assert property (o_sync_event |=> !o_sync_event) else $error("event wider than one cycle");
  AST_EVENT_ON_RISE: assert property (o_sync_event |-> o_sync_sampled && !$past(o_sync_sampled))
    else $error("event without sample rise");
  AST_RECV_BY_WRITE: assert property ($changed(o_sync_receiver_active) |-> !$past(i_spi_cs_n))
    else $error("receiver changed outside frame");
  AST_CLK_PECL_BY_WRITE: assert property ($changed(o_device_clock_pecl_mode) |-> !$past(i_spi_cs_n))
    else $error("clock pecl changed outside frame");
  AST_SYNC_PECL_BY_WRITE: assert property ($changed(o_sync_input_pecl_mode) |-> !$past(i_spi_cs_n))
    else $error("sync pecl changed outside frame");
  AST_ANALOG_NS_BY_WRITE: assert property ($changed(o_analog_rail_noise_suppress) |-> !$past(i_spi_cs_n))
    else $error("analog suppress changed outside frame");
  AST_CLOCK_NS_BY_WRITE: assert property ($changed(o_clock_rail_noise_suppress) |-> !$past(i_spi_cs_n))
    else $error("clock suppress changed outside frame");
  cover property (o_sync_event);
  cover property ($rose(o_sync_receiver_active));
  cover property ($rose(o_analog_rail_noise_suppress));
endmodule : sysref_clock_control_regs_checker
bind sysref_clock_control_regs sysref_clock_control_regs_checker sysref_clock_control_regs_checker_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n), .i_spi_sdi(i_spi_sdi),
  .o_spi_sdo(o_spi_sdo), .i_sync_ref(i_sync_ref), .o_sync_event(o_sync_event), .o_sync_sampled(o_sync_sampled),
  .o_sync_receiver_active(o_sync_receiver_active), .o_device_clock_pecl_mode(o_device_clock_pecl_mode),
  .o_sync_input_pecl_mode(o_sync_input_pecl_mode), .o_analog_rail_noise_suppress(o_analog_rail_noise_suppress),
  .o_clock_rail_noise_suppress(o_clock_rail_noise_suppress));
`default_nettype wire

//--- sysref_clock_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_control_regs_tb;
  typedef struct packed {logic [14:0] a; logic [7:0] w; logic [7:0] r; logic [4:0] p;} row_t;
  logic clk, rst, sclk, cs_n, sdi, go, s;
  wire logic sdo, sref, ev, smp, rcv, cpe, spe, ans, cns;
  int err_total, total_checks, n0, n1;
  row_t rows [7];
  sysref_clock_control_regs sysref_clock_control_regs_i (.i_clk(clk), .i_reset(rst), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .i_sync_ref(sref), .o_sync_event(ev),
    .o_sync_sampled(smp), .o_sync_receiver_active(rcv), .o_device_clock_pecl_mode(cpe),
    .o_sync_input_pecl_mode(spe), .o_analog_rail_noise_suppress(ans), .o_clock_rail_noise_suppress(cns));
  sync_source sync_source_i (.i_clk(clk), .i_go(go), .o_sync_ref(sref));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
    cs_n = 0;
    cyc(4);
    for (int k = 0; k < 24; k++)
    begin
      sdi = f[23-k];
      cyc(4);
      sclk = 1;
      cyc(4);
      if (k >= 15 && k <= 22) rd[22-k] = sdo;
      sclk = 0;
    end
    cyc(4);
    cs_n = 1;
    cyc(4);
  endtask : xfer
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask : wr
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkn
  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] x;
    xfer({1'b1, a, 8'h00}, x);
    chk8(x, exp);
  endtask : rdchk
  task automatic pulse(output int n, output logic seen);
    n = 100;
    seen = 0;
    go = 1;
    cyc(1);
    go = 0;
    for (int c = 0; c < 100; c++)
    begin
      if (smp === 1'b1 && n == 100) n = c;
      if (ev === 1'b1) seen = 1;
      cyc(1);
    end
  endtask : pulse
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial
  begin
    #500000;
    err_total++;
    results();
  end
  initial
  begin
    rst = 0; sclk = 0; cs_n = 1; sdi = 0; go = 0; err_total = 0; total_checks = 0;
    #1;
    rst = 1;
    // receiver before processor, reserved bits kept at reset values
    rows[0] = {15'h0029, 8'ha0, 8'ha0, 5'h10};
    rows[1] = {15'h002a, 8'h06, 8'h06, 5'h1c};
    rows[2] = {15'h002b, 8'h15, 8'h15, 5'h1f};
    rows[3] = {15'h002c, 8'hff, 8'h00, 5'h1f};
    rows[4] = {15'h0040, 8'h5a, 8'h00, 5'h1f};
    rows[5] = {15'h002a, 8'h00, 8'h00, 5'h13};
    rows[6] = {15'h002b, 8'h10, 8'h10, 5'h10};
    cyc(20);
    rst = 0;
    cyc(2);
    rdchk(15'h0029, sysref_clock_control_pkg::RST_CTRL_ZERO);
    rdchk(15'h002a, sysref_clock_control_pkg::RST_CTRL_ONE);
    rdchk(15'h002b, sysref_clock_control_pkg::RST_CTRL_TWO);
    rdchk(15'h002c, 8'h00);
    $display("reset values test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
      chk8({3'h0, rcv, cpe, spe, ans, cns}, {3'h0, rows[i].p});
    end
    $display("register table test done");
    wr(15'h0029, 8'he0);
    pulse(n0, s);
    chk8({7'h0, s}, 8'h01);
    rdchk(15'h002c, 8'h01);
    rdchk(15'h002d, 8'h00);
    wr(15'h002c, 8'h00);
    rdchk(15'h002c, 8'h01);
    wr(15'h0029, 8'he4);
    pulse(n1, s);
    chkn(n1 - n0, 8);
    wr(15'h0029, 8'hf4);
    pulse(n1, s);
    chkn(n1 - n0, 4);
    wr(15'h0029, 8'ha0);
    pulse(n1, s);
    chk8({7'h0, s}, 8'h00);
    $display("sync path test done");
    wr(15'h002a, 8'h01);
    cyc(60);
    chk8({7'h0, smp}, 8'h01);
    wr(15'h002a, 8'h00);
    cyc(60);
    chk8({7'h0, smp}, 8'h00);
    $display("invert test done");
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(2);
    rdchk(15'h0029, sysref_clock_control_pkg::RST_CTRL_ZERO);
    chk8({7'h0, rcv}, 8'h00);
    $display("second reset test done");
    results();
  end
endmodule : sysref_clock_control_regs_tb
`default_nettype wire
